// ===== ams_seq.sv
// converter input sequencer, result buffer fill and samples-per-irq logic
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module ams_seq #(
    parameter int RES_W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conv_result,
    output logic sample_hold,
    output logic conv_start,
    output logic [3:0] pos_input,
    output logic neg_is_input,
    output logic conversion_irq_flag
);
    logic [31:0] control_register_one;
    logic [7:0] control_register_two;
    logic [31:0] channel_select_register;
    logic [15:0] scan_list_register;
    ams_pkg::ams_state_e state;
    logic use_b;
    logic [3:0] scan_ptr;
    logic scan_first;
    logic [3:0] wr_ptr;
    logic [3:0] smp_cnt;
    logic active_half_flag;
    logic acq_hold;
    logic [RES_W-1:0] mem_rdata;
    logic rd_pend;
    logic [3:0] next_scan;

    // decode
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire is_buf = paddr[7:6] == ams_pkg::ADDR_BUF[7:6];
    wire mapped = is_buf || paddr == ams_pkg::ADDR_CON1
        || paddr == ams_pkg::ADDR_CON2 || paddr == ams_pkg::ADDR_CHS
        || paddr == ams_pkg::ADDR_SCAN || paddr == ams_pkg::ADDR_FLAG;
    wire module_on = control_register_one[ams_pkg::CON1_ON];
    wire auto_acquire = control_register_one[ams_pkg::CON1_AUTO];
    wire acquire_request = control_register_one[ams_pkg::CON1_ACQ];
    wire alt_mux_enable = control_register_two[ams_pkg::CON2_ALT];
    wire split_buffer_mode = control_register_two[ams_pkg::CON2_SPLIT];
    wire [3:0] conversions_per_irq =
        control_register_two[ams_pkg::CON2_CONVERSIONS_PER_IRQ_LO +: 4];
    wire scan_enable = scan_list_register != 16'h0000 &&
        control_register_two[ams_pkg::CON2_HALF - 1];
    wire [3:0] mux_a_pos_select =
        channel_select_register[ams_pkg::CHS_A_POS_LO +: 4];
    wire mux_a_neg_select = channel_select_register[ams_pkg::CHS_A_NEG];
    wire [3:0] mux_b_pos_select =
        channel_select_register[ams_pkg::CHS_B_POS_LO +: 4];
    wire mux_b_neg_select = channel_select_register[ams_pkg::CHS_B_NEG];
    // mux B only when alternating
    wire sel_b = alt_mux_enable && use_b;
    wire [3:0] a_pos = scan_enable ? scan_ptr : mux_a_pos_select;
    wire [3:0] next_pos = sel_b ? mux_b_pos_select : a_pos;
    wire next_neg = sel_b ? mux_b_neg_select : mux_a_neg_select;
    wire wr_con1 = wr && paddr == ams_pkg::ADDR_CON1;
    wire wr_con2 = wr && paddr == ams_pkg::ADDR_CON2;
    wire on_rise = wr_con1 && pwdata[ams_pkg::CON1_ON] && !module_on;
    wire alt_rise = wr_con2 && pwdata[ams_pkg::CON2_ALT] && !alt_mux_enable;
    wire restart = on_rise || alt_rise;
    wire done = state == ams_pkg::AMS_CONVERT && conv_done && module_on;
    wire irq_hit = done && smp_cnt == conversions_per_irq;
    // clearing acquire_request ends sampling
    wire manual_end = wr_con1 && !pwdata[ams_pkg::CON1_ACQ] && acq_hold;
    wire [3:0] base = active_half_flag ? ams_pkg::HALF_BASE
        : ams_pkg::LOW_BASE;
    wire [3:0] lin_next = wr_ptr + 4'h1;
    // stay inside active half when split
    wire [3:0] split_next = {wr_ptr[3], lin_next[2:0]};
    wire [3:0] adv_ptr = split_buffer_mode ? split_next : lin_next;
    wire [31:0] reg_rd =
        paddr == ams_pkg::ADDR_CON1 ? control_register_one :
        paddr == ams_pkg::ADDR_CON2 ? {24'h000000,
            active_half_flag, control_register_two[6:0]} :
        paddr == ams_pkg::ADDR_CHS ? channel_select_register :
        paddr == ams_pkg::ADDR_SCAN ? {16'h0000, scan_list_register} :
        paddr == ams_pkg::ADDR_FLAG ? {31'h00000000, conversion_irq_flag} :
        32'h00000000;

    ams_scan_ptr u_scan (
        .list(scan_list_register),
        .cur(scan_ptr),
        .first(scan_first),
        .next(next_scan)
    );

    ams_result_mem #(.WIDTH(RES_W), .DEPTH(16)) u_mem (
        .pclk(pclk),
        .we(done),
        .waddr(wr_ptr),
        .wdata(conv_result),
        .raddr(paddr[5:2]),
        .rdata(mem_rdata)
    );

    // apb: register reads answer one cycle, buffer reads two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            rd_pend <= 1'b0;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                rd_pend <= !pwrite && is_buf;
                pready <= !(!pwrite && is_buf);
                pslverr <= !mapped;
                prdata <= pwrite ? 32'h00000000 : reg_rd;
            end else if (rd_pend) begin
                rd_pend <= 1'b0;
                pready <= 1'b1;
                prdata <= {{(32 - RES_W){1'b0}}, mem_rdata};
            end
        end
    end

    // software registers; hardware set of flag beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_register_one <= 32'h00000000;
            control_register_two <= 8'h00;
            channel_select_register <= 32'h00000000;
            scan_list_register <= 16'h0000;
            conversion_irq_flag <= 1'b0;
        end else begin
            if (wr_con1) begin
                control_register_one <= pwdata;
            end
            if (wr_con2) begin
                control_register_two <= pwdata[7:0];
            end
            if (wr && paddr == ams_pkg::ADDR_CHS) begin
                channel_select_register <= pwdata;
            end
            if (wr && paddr == ams_pkg::ADDR_SCAN) begin
                scan_list_register <= pwdata[15:0];
            end
            if (irq_hit) begin
                conversion_irq_flag <= 1'b1;
            end else if (wr && paddr == ams_pkg::ADDR_FLAG
                    && !pwdata[0]) begin
                conversion_irq_flag <= 1'b0;
            end
        end
    end

    // sample / convert sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ams_pkg::AMS_IDLE;
            sample_hold <= 1'b0;
            conv_start <= 1'b0;
            acq_hold <= 1'b0;
            pos_input <= 4'h0;
            neg_is_input <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            pos_input <= next_pos;
            neg_is_input <= next_neg;
            unique case (state)
                ams_pkg::AMS_IDLE: begin
                    // start on software request or automatically
                    if (module_on && (auto_acquire ||
                            (wr_con1 && pwdata[ams_pkg::CON1_ACQ]))) begin
                        state <= ams_pkg::AMS_SAMPLE;
                        sample_hold <= 1'b1;
                        acq_hold <= !auto_acquire;
                    end
                end
                ams_pkg::AMS_SAMPLE: begin
                    // auto mode converts at once; manual waits for clear
                    if (!module_on) begin
                        state <= ams_pkg::AMS_IDLE;
                        sample_hold <= 1'b0;
                    end else if (!acq_hold || manual_end) begin
                        state <= ams_pkg::AMS_CONVERT;
                        sample_hold <= 1'b0;
                        conv_start <= 1'b1;
                        acq_hold <= 1'b0;
                    end
                end
                ams_pkg::AMS_CONVERT: begin
                    if (!module_on || done) begin
                        // no restart unless auto_acquire
                        state <= ams_pkg::AMS_IDLE;
                    end
                end
                default: begin
                    state <= ams_pkg::AMS_IDLE;
                end
            endcase
        end
    end

    // mux phase, scan pointer, buffer pointer and half tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_b <= 1'b0;
            scan_ptr <= 4'h0;
            scan_first <= 1'b1;
            wr_ptr <= 4'h0;
            smp_cnt <= 4'h0;
            active_half_flag <= 1'b0;
        end else if (restart) begin
            use_b <= 1'b0;
            scan_first <= 1'b1;
            scan_ptr <= 4'h0;
            wr_ptr <= ams_pkg::LOW_BASE;
            smp_cnt <= 4'h0;
            active_half_flag <= 1'b0;
        end else begin
            if (scan_first && scan_enable) begin
                scan_ptr <= next_scan; // seed at lowest entry
                scan_first <= 1'b0;
            end else if (done && scan_enable && !sel_b) begin
                scan_ptr <= next_scan;
            end
            // a conversion is never lost to the seeding cycle
            if (done) begin
                use_b <= alt_mux_enable && !use_b;
                if (irq_hit) begin
                    smp_cnt <= 4'h0;
                    if (split_buffer_mode) begin
                        active_half_flag <= !active_half_flag;
                        wr_ptr <= active_half_flag ? ams_pkg::LOW_BASE
                            : ams_pkg::HALF_BASE;
                    end else begin
                        wr_ptr <= ams_pkg::LOW_BASE;
                    end
                end else begin
                    smp_cnt <= smp_cnt + 4'h1;
                    wr_ptr <= adv_ptr;
                end
            end
        end
    end

    a_first_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        restart |=> !use_b)
        else $error("phase not reset to mux A");
    alt_swap_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done && alt_mux_enable && !restart |=> use_b != $past(use_b))
        else $error("no mux swap");
    no_alt_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !alt_mux_enable |=> pos_input == $past(a_pos)
        && neg_is_input == $past(mux_a_neg_select))
        else $error("mux B without alt");
    b_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_b |=> pos_input == $past(mux_b_pos_select))
        else $error("mux B input wrong");
    a_field_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sel_b && !scan_enable |=> pos_input == $past(mux_a_pos_select))
        else $error("mux A input wrong");
    scan_pos_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sel_b && scan_enable |=> pos_input == $past(scan_ptr))
        else $error("scan input wrong");
    neg_a_ref_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sel_b && !mux_a_neg_select |=> !neg_is_input)
        else $error("mux A negative not reference");
    neg_b_ref_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        sel_b && !mux_b_neg_select |=> !neg_is_input)
        else $error("mux B negative not reference");
    irq_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_hit |=> conversion_irq_flag)
        else $error("flag missed");
    half_go_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_hit && split_buffer_mode && !active_half_flag && !restart
        |=> wr_ptr == ams_pkg::HALF_BASE)
        else $error("no upper half");
    half_back_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_hit && split_buffer_mode && active_half_flag && !restart
        |=> wr_ptr == ams_pkg::LOW_BASE && !active_half_flag)
        else $error("no lower half");
    half_base_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_hit && split_buffer_mode && !restart
        |=> wr_ptr == base && active_half_flag != $past(active_half_flag))
        else $error("half flag and pointer disagree");
    lin_step_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done && !split_buffer_mode && !irq_hit && !restart
        |=> wr_ptr == $past(wr_ptr) + 4'h1)
        else $error("buffer pointer skipped");
    half_keep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        done && split_buffer_mode && !irq_hit && !restart
        |=> wr_ptr[3] == $past(wr_ptr[3]))
        else $error("left active half");
    start_req_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == ams_pkg::AMS_IDLE && module_on && wr_con1
        && pwdata[ams_pkg::CON1_ACQ] |=> sample_hold)
        else $error("request did not start sampling");
    end_conv_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == ams_pkg::AMS_SAMPLE && module_on && manual_end
        |=> conv_start && !sample_hold)
        else $error("clear did not start conversion");
    no_auto_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == ams_pkg::AMS_CONVERT && done && !auto_acquire
        |=> state == ams_pkg::AMS_IDLE ##1
        (state == ams_pkg::AMS_IDLE || $past(wr_con1)))
        else $error("auto restart");
endmodule : ams_seq

// ===== ams_pkg.sv
// shared constants for the converter scan and buffer sequencer
package ams_pkg;
    localparam logic [7:0] ADDR_CON1 = 8'h00;
    localparam logic [7:0] ADDR_CON2 = 8'h04;
    localparam logic [7:0] ADDR_CHS = 8'h08;
    localparam logic [7:0] ADDR_SCAN = 8'h0C;
    localparam logic [7:0] ADDR_FLAG = 8'h10;
    localparam logic [7:0] ADDR_BUF = 8'h40;
    // control register one fields
    localparam int CON1_ON = 15;
    localparam int CON1_AUTO = 2;
    localparam int CON1_ACQ = 1;
    // control register two fields
    localparam int CON2_ALT = 0;
    localparam int CON2_SPLIT = 1;
    localparam int CON2_CONVERSIONS_PER_IRQ_LO = 2;
    localparam int CON2_HALF = 7;
    // channel select fields
    localparam int CHS_A_POS_LO = 16;
    localparam int CHS_A_NEG = 23;
    localparam int CHS_B_POS_LO = 24;
    localparam int CHS_B_NEG = 31;
    localparam logic [3:0] HALF_BASE = 4'h8;
    localparam logic [3:0] LOW_BASE = 4'h0;
    localparam int CONV_CYCLES = 12;
    typedef enum logic [2:0] {
        AMS_IDLE = 3'b001,
        AMS_SAMPLE = 3'b010,
        AMS_CONVERT = 3'b100
    } ams_state_e;
endpackage : ams_pkg

// ===== ams_result_mem.sv
// sixteen-word result memory with registered read data
`timescale 1ns/10ps
module ams_result_mem #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : ams_result_mem

// ===== ams_scan_ptr.sv
// scan-list pointer: next enabled entry above current, wrapping to lowest
`timescale 1ns/10ps
module ams_scan_ptr (
    input wire logic [15:0] list,
    input wire logic [3:0] cur,
    input wire logic first,
    output logic [3:0] next
);
    always_comb begin
        logic found;
        found = 1'b0;
        next = cur;
        // lowest enabled entry first, used on wrap or restart
        for (int i = 15; i >= 0; i--) begin
            if (list[i]) begin
                next = 4'(i);
            end
        end
        if (!first) begin
            for (int i = 0; i < 16; i++) begin
                if (!found && list[i] && 4'(i) > cur) begin
                    next = 4'(i);
                    found = 1'b1;
                end
            end
        end
    end
endmodule : ams_scan_ptr

// ===== ams_sar_model.sv
// behavioural converter core answering conversion starts
`timescale 1ns/10ps
module ams_sar_model #(
    parameter int RES_W = 10
) (
    input wire logic pclk,
    input wire logic conv_start,
    input wire logic slow,
    input wire logic [3:0] pos_input,
    input wire logic neg_is_input,
    output logic conv_done,
    output logic [RES_W-1:0] conv_result
);
    int cnt;
    logic [RES_W-1:0] last;
    // result carries the inputs held at conversion start, so the
    // buffer contents reveal which inputs were sampled
    initial begin
        conv_done = 1'b0;
        conv_result = '0;
        cnt = 0;
        last = '0;
        forever begin
            @(posedge pclk);
            if (conv_start === 1'b1) begin
                last = RES_W'({pos_input, neg_is_input, cnt[4:0]});
                repeat (slow ? 12 : 1) @(posedge pclk);
                conv_done <= 1'b1;
                conv_result <= last;
                cnt++;
                @(posedge pclk);
                conv_done <= 1'b0;
                // stale result is not kept on the lines
                conv_result <= ~last;
            end
        end
    end
endmodule : ams_sar_model

// ===== ams_seq_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
module ams_seq_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic conv_done, sample_hold, conv_start, neg_is_input, irq, slow;
    logic [9:0] conv_result;
    logic [3:0] pos_input;
    int fails, check_count, k, ptr, grp, half, n, alt, split, scan, seq;
    logic [31:0] chs, list;
    logic [9:0] exp_buf [16];
    localparam logic [31:0] ON = 32'h1 << ams_pkg::CON1_ON;

    ams_seq ams_seq_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_done(conv_done),
        .conv_result(conv_result), .sample_hold(sample_hold),
        .conv_start(conv_start), .pos_input(pos_input),
        .neg_is_input(neg_is_input), .conversion_irq_flag(irq));
    ams_sar_model ams_sar_model_i (.pclk(pclk), .conv_start(conv_start),
        .slow(slow), .pos_input(pos_input), .neg_is_input(neg_is_input),
        .conv_done(conv_done), .conv_result(conv_result));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        check_count++;
        if (a !== e) begin
            fails++;
            $display("mismatch t=%0t got %h exp %h", $time, a, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic er);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
        chk(32'(t < 20), 32'h1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, d, r, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic er;
        apb(1'b0, a, 32'h0, r, er);
    endtask : rd

    task automatic wait_start();
        int t;
        t = 0;
        do @(posedge pclk); while (conv_start !== 1'b1 && ++t < 60);
        chk(32'(t < 60), 32'h1);
    endtask : wait_start

    task automatic cfg(input int a, input int s, input int m, input int sc,
        input logic [31:0] c, input logic [31:0] l);
        alt = a;
        split = s;
        n = m + 1;
        scan = sc;
        chs = c;
        list = l;
        k = 0;
        ptr = -1;
        grp = 0;
        half = 0;
        wr(ams_pkg::ADDR_CON1, 32'h0);
        wr(ams_pkg::ADDR_CON2, 32'(a | s << 1 | m << 2 | sc << 6));
        wr(ams_pkg::ADDR_CHS, c);
        wr(ams_pkg::ADDR_SCAN, l);
        wr(ams_pkg::ADDR_FLAG, 32'h0);
        wr(ams_pkg::ADDR_CON1, ON);
    endtask : cfg

    // one manual acquire and convert, checked against the expected inputs and buffer words
    task automatic sample();
        logic [31:0] r;
        logic ua, en;
        logic [3:0] ep;
        int t, b;
        slow <= 1'($urandom);
        wr(ams_pkg::ADDR_CON1, ON | 32'h2);
        // sample the registered output once it has settled
        @(negedge pclk);
        chk({31'h0, sample_hold}, 32'h1);
        wr(ams_pkg::ADDR_CON1, ON);
        ua = (alt == 0) || (k % 2 == 0);
        if (ua && scan != 0) begin
            do ptr = (ptr + 1) % 16; while (!list[ptr]);
            ep = 4'(ptr);
        end else ep = ua ? chs[19:16] : chs[27:24];
        en = ua ? chs[23] : chs[31];
        wait_start();
        if (!ua) chk(32'(pos_input), 32'(ep));
        else if (scan != 0) chk(32'(pos_input), 32'(ep));
        else chk(32'(pos_input), 32'(ep));
        chk({31'h0, neg_is_input}, {31'h0, en});
        t = 0;
        do @(posedge pclk); while (conv_done !== 1'b1 && ++t < 60);
        chk(32'(t < 60), 32'h1);
        b = split * half * 8;
        exp_buf[b + grp] = {ep, en, 5'(seq)};
        seq++;
        k++;
        grp++;
        repeat (8) @(posedge pclk);
        chk({31'h0, sample_hold}, 32'h0);
        rd(ams_pkg::ADDR_FLAG, r);
        chk(r, 32'(grp == n));
        if (grp == n) begin
            wr(ams_pkg::ADDR_FLAG, 32'h0);
            if (split != 0 || k == n) for (t = 0; t < n; t++) begin
                rd(8'(ams_pkg::ADDR_BUF + 8'(4 * (b + t))), r);
                chk(r, {22'h0, exp_buf[b + t]});
            end
            grp = 0;
            half ^= split;
            rd(ams_pkg::ADDR_CON2, r);
            chk({31'h0, r[7]}, 32'(half));
        end
    endtask : sample

    initial begin
        #200000;
        fails++;
        summarize();
    end

    initial begin
        int i, j;
        logic [31:0] r;
        logic er;
        {presetn, psel, penable, pwrite, slow} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fails = 0;
        check_count = 0;
        seq = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'hD079AD96));
        // alternate inputs with two halves, four per interrupt
        cfg(1, 1, 3, 0, $urandom, 32'h0);
        repeat (12) sample();
        // scan list of two entries feeding mux A, wraps once
        i = $urandom % 16;
        j = (i + 1 + $urandom % 15) % 16;
        cfg(1, 0, 3, 1, $urandom, (32'h1 << i) | (32'h1 << j));
        repeat (6) sample();
        // alternate off: mux B setting must never appear
        cfg(0, 0, 0, 0, 32'h0100_0000, 32'h0);
        repeat (2) sample();
        apb(1'b0, 8'h20, 32'h0, r, er);
        chk({31'h0, er}, 32'h1);
        chk(r, 32'h0);
        // automatic acquire restarts by itself
        wr(ams_pkg::ADDR_CON1, ON | 32'h4);
        repeat (2) wait_start();
        wr(ams_pkg::ADDR_CON1, 32'h0);
        summarize();
    end
endmodule : ams_seq_tb
